// ===== inc/cis_pkg.sv
// Purpose: shared constants and types of the instruction subset executor
// Assumes: 32-bit avalon-mm register bus, byte addressed, word aligned
// Notes:   offsets, field positions, counts and the pc, w, latch, flag and watchdog reset values live here

package cis_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PC_W      = 15;
	localparam int DATA_W    = 8;
	localparam int FADDR_W   = 7;
	localparam int LATCH_W   = 7;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W      = 4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_INSN     = 6'h00;
	localparam logic [5:0] REG_PC       = 6'h04;
	localparam logic [5:0] REG_W        = 6'h08;
	localparam logic [5:0] REG_LATCH    = 6'h0c;
	localparam logic [5:0] REG_STATUS   = 6'h10;
	localparam logic [5:0] REG_WDOG     = 6'h14;
	localparam logic [5:0] REG_MEM_ADDR = 6'h18;
	localparam logic [5:0] REG_MEM_DATA = 6'h1c;
	localparam logic [5:0] REG_STACK    = 6'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int INSN_F_LSB  = 0;
	localparam int INSN_B_LSB  = 7;
	localparam int INSN_D_BIT  = 10;
	localparam int INSN_K_LSB  = 16;
	localparam int INSN_OP_LSB = 28;
	localparam int ST_Z_BIT    = 0;
	localparam int ST_SLP_BIT  = 1;
	localparam int ST_TO_BIT   = 2;
	localparam int ST_BUSY_BIT = 8;
	localparam int WD_PRE_LSB  = 8;
	localparam int STK_SP_LSB  = 16;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [14:0] PC_RST     = 15'h0000;
	localparam logic [7:0]  W_RST      = 8'h00;
	localparam logic [6:0]  LATCH_RST  = 7'h00;
	localparam logic        Z_RST      = 1'b0;
	localparam logic        TO_N_RST   = 1'b1;
	localparam logic        SLP_N_RST  = 1'b1;
	localparam logic [7:0]  WDOG_RST   = 8'h00;
	localparam logic [7:0]  PRE_RST    = 8'h00;
	localparam logic [7:0]  WDOG_PRE_MAX = 8'hff;
	localparam logic [1:0]  RD_IDLE    = 2'h0;
	localparam logic [1:0]  RD_WAIT    = 2'h1;
	localparam logic [1:0]  RD_DONE    = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_BRANCH = 4'h1,
		OP_BSET   = 4'h2,
		OP_BTSKIP = 4'h3,
		OP_CALLK  = 4'h4,
		OP_WDCLR  = 4'h5,
		OP_CALLA  = 4'h6,
		OP_COMP   = 4'h7,
		OP_CLRREG = 4'h8,
		OP_DEC    = 4'h9
	} cis_op_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_FETCH  = 4'b0010,
		ST_EXEC   = 4'b0100,
		ST_SECOND = 4'b1000
	} cis_state_t;

endpackage

// ===== verilog/cis_ram.sv
// Purpose: data register file, 128 bytes, registered read
// Assumes: single port, write and read address shared
// Notes:   read data reflect the address one clock earlier

`timescale 1ns/1ns

module cis_ram
	import cis_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               we,
	input  wire logic [FADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0]  wdata,
	output logic      [DATA_W-1:0]  rdata_r
);

	logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= we ? wdata : mem[addr];
		end
	end

endmodule // cis_ram

// ===== verilog/cis_stack.sv
// Purpose: return address stack, circular, push only from this block
// Assumes: pops belong to instructions outside this block
// Notes:   overflow wraps and overwrites the oldest entry

`timescale 1ns/1ns

module cis_stack
	import cis_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            push,
	input  wire logic [PC_W-1:0] push_data,
	output logic      [PC_W-1:0] top_r,
	output logic      [SP_W-1:0] sp_r
);

	logic [PC_W-1:0] mem [0:STACK_DEPTH-1];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[sp_r] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			top_r <= 15'h0000;
			sp_r  <= 4'h0;
		end else if (push) begin
			top_r <= push_data;
			sp_r  <= sp_r + 4'h1;
		end
	end

endmodule // cis_stack

// ===== verilog/cis_exec.sv
// Purpose: executes a subset of the 8-bit core instructions issued over avalon-mm
// Assumes: one instruction cycle is one clock of the exec or second state
// Notes:   bus requests stall while an instruction is in flight
//
// Behaviour
// RULE_01 - relative branch by accumulator loads pc with current address plus one plus w
// RULE_02 - that branch treats w as unsigned offset added to incremented pc
// RULE_03 - bit set forces chosen bit of addressed register to one, flags unchanged
// RULE_04 - bit test skips next instruction when bit is one, taking two cycles
// RULE_05 - immediate call pushes address plus one, loads 11-bit operand into pc low
// RULE_06 - immediate call takes pc bits 14:11 from upper latch bits 6:3
// RULE_07 - watchdog clear zeroes watchdog counter and its prescaler
// RULE_08 - watchdog clear sets both active-low expiry and power-down bits
// RULE_09 - accumulator call pushes address plus one, pc from w and upper latch
// RULE_10 - both calls take two instruction cycles and change no flag
// RULE_11 - complement inverts register into w or register by selector, updates zero
// RULE_12 - clear register writes zero to addressed register and sets zero flag
// RULE_13 - decrement subtracts one into w or register by selector, updates zero
// RULE_14 - complement and decrement set zero on zero result, clear otherwise
// RULE_15 - bit set, watchdog clear, complement, clear and decrement take one cycle

`timescale 1ns/1ns

module cis_exec
	import cis_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		cis_state_t         state;
		logic [PC_W-1:0]    pc;
		logic [DATA_W-1:0]  w;
		logic [LATCH_W-1:0] latch;
		logic               z;
		logic               to_n;
		logic               slp_n;
		logic [7:0]         wdog;
		logic [7:0]         pre;
		logic [3:0]         op;
		logic [FADDR_W-1:0] f;
		logic [2:0]         b;
		logic               d;
		logic [10:0]        k;
		logic [FADDR_W-1:0] mem_addr;
		logic [1:0]         rd_stage;
		logic [31:0]        rdata;
	} cis_st_t;

	localparam cis_st_t ST_RST = '{
		state:    ST_IDLE,
		pc:       PC_RST,
		w:        W_RST,
		latch:    LATCH_RST,
		z:        Z_RST,
		to_n:     TO_N_RST,
		slp_n:    SLP_N_RST,
		wdog:     WDOG_RST,
		pre:      PRE_RST,
		op:       4'h0,
		f:        7'h00,
		b:        3'h0,
		d:        1'b0,
		k:        11'h000,
		mem_addr: 7'h00,
		rd_stage: RD_IDLE,
		rdata:    32'h0000_0000
	};

	cis_st_t             s_r;
	cis_st_t             s_nxt;
	logic [1:0]          rst_sync_r;
	logic                rst_n;
	logic                busy;
	logic                mem_we;
	logic [FADDR_W-1:0]  mem_a;
	logic [DATA_W-1:0]   mem_wd;
	logic [DATA_W-1:0]   mem_q;
	logic                push;
	logic [PC_W-1:0]     push_d;
	logic [PC_W-1:0]     stk_top;
	logic [SP_W-1:0]     stk_sp;
	logic [31:0]         cur;
	logic [31:0]         be_mask;
	logic [31:0]         merged;
	logic [PC_W-1:0]     pc_inc;
	logic [DATA_W-1:0]   res;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_r[1];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	cis_ram u_ram (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (mem_we),
		.addr    (mem_a),
		.wdata   (mem_wd),
		.rdata_r (mem_q)
	);

	cis_stack u_stack (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (push),
		.push_data (push_d),
		.top_r     (stk_top),
		.sp_r      (stk_sp)
	);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	assign busy = (s_r.state != ST_IDLE);

	// reads take two stall cycles so the ram output is always settled
	assign avs_waitrequest = busy ? (avs_read | avs_write) : (avs_read && (s_r.rd_stage != RD_DONE));
	assign avs_readdata    = s_r.rdata;

	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign merged  = (cur & ~be_mask) | (avs_writedata & be_mask);
	assign pc_inc  = s_r.pc + 15'h0001;

	// ----------------------------------------------------------------
	// register read view
	// ----------------------------------------------------------------
	always_comb begin
		cur = 32'h0000_0000;
		case (avs_address)
			REG_INSN: begin
				cur[INSN_F_LSB +: FADDR_W] = s_r.f;
				cur[INSN_B_LSB +: 3]       = s_r.b;
				cur[INSN_D_BIT]            = s_r.d;
				cur[INSN_K_LSB +: 11]      = s_r.k;
				cur[INSN_OP_LSB +: 4]      = s_r.op;
			end
			REG_PC: begin
				cur[PC_W-1:0] = s_r.pc;
			end
			REG_W: begin
				cur[DATA_W-1:0] = s_r.w;
			end
			REG_LATCH: begin
				cur[LATCH_W-1:0] = s_r.latch;
			end
			REG_STATUS: begin
				cur[ST_Z_BIT]    = s_r.z;
				cur[ST_SLP_BIT]  = s_r.slp_n;
				cur[ST_TO_BIT]   = s_r.to_n;
				cur[ST_BUSY_BIT] = busy;
			end
			REG_WDOG: begin
				cur[7:0]              = s_r.wdog;
				cur[WD_PRE_LSB +: 8]  = s_r.pre;
			end
			REG_MEM_ADDR: begin
				cur[FADDR_W-1:0] = s_r.mem_addr;
			end
			REG_MEM_DATA: begin
				cur[DATA_W-1:0] = mem_q;
			end
			REG_STACK: begin
				cur[PC_W-1:0]             = stk_top;
				cur[STK_SP_LSB +: SP_W]   = stk_sp;
			end
			default: begin
				cur = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt  = s_r;
		mem_we = 1'b0;
		mem_a  = s_r.mem_addr;
		mem_wd = 8'h00;
		push   = 1'b0;
		push_d = pc_inc;
		res    = 8'h00;

		// free-running watchdog; expiry handling lives outside this block
		s_nxt.pre = s_r.pre + 8'h01;
		if (s_r.pre == WDOG_PRE_MAX) begin
			s_nxt.wdog = s_r.wdog + 8'h01;
		end

		// bus writes, only accepted while idle
		if (avs_write && !busy) begin
			case (avs_address)
				REG_INSN: begin
					s_nxt.f     = merged[INSN_F_LSB +: FADDR_W];
					s_nxt.b     = merged[INSN_B_LSB +: 3];
					s_nxt.d     = merged[INSN_D_BIT];
					s_nxt.k     = merged[INSN_K_LSB +: 11];
					s_nxt.op    = merged[INSN_OP_LSB +: 4];
					s_nxt.state = ST_FETCH;
				end
				REG_PC: begin
					s_nxt.pc = merged[PC_W-1:0];
				end
				REG_W: begin
					s_nxt.w = merged[DATA_W-1:0];
				end
				REG_LATCH: begin
					s_nxt.latch = merged[LATCH_W-1:0];
				end
				REG_STATUS: begin
					s_nxt.z    = merged[ST_Z_BIT];
					s_nxt.slp_n = merged[ST_SLP_BIT];
					s_nxt.to_n = merged[ST_TO_BIT];
				end
				REG_MEM_ADDR: begin
					s_nxt.mem_addr = merged[FADDR_W-1:0];
				end
				REG_MEM_DATA: begin
					mem_we = 1'b1;
					mem_wd = merged[DATA_W-1:0];
				end
				default: begin
					mem_we = 1'b0;
				end
			endcase
		end

		// bus reads: stage 1 lets the ram output settle, stage 2 answers
		if (avs_read && !busy) begin
			case (s_r.rd_stage)
				RD_IDLE: begin
					s_nxt.rd_stage = RD_WAIT;
				end
				RD_WAIT: begin
					s_nxt.rdata    = cur;
					s_nxt.rd_stage = RD_DONE;
				end
				default: begin
					s_nxt.rd_stage = RD_IDLE;
				end
			endcase
		end

		// instruction sequencing
		case (s_r.state)
			ST_IDLE: begin
				s_nxt.state = s_nxt.state;
			end
			ST_FETCH: begin
				mem_a       = s_r.f;
				s_nxt.state = ST_EXEC;
			end
			ST_EXEC: begin
				mem_a       = s_r.f;
				s_nxt.pc    = pc_inc;
				s_nxt.state = ST_IDLE;
				case (s_r.op)
					OP_BRANCH: begin
						// RULE_01 pc plus one plus w
						// RULE_02 w zero-extended, unsigned
						s_nxt.pc    = pc_inc + {7'h00, s_r.w};
						s_nxt.state = ST_SECOND;
					end
					OP_BSET: begin
						// RULE_03 force bit, no flags
						mem_we = 1'b1;
						mem_wd = mem_q | (8'h01 << s_r.b);
					end
					OP_BTSKIP: begin
						// RULE_04 skip on one, second cycle is the nop
						if (mem_q[s_r.b]) begin
							s_nxt.pc    = s_r.pc + 15'h0002;
							s_nxt.state = ST_SECOND;
						end
					end
					OP_CALLK: begin
						// RULE_05 push return, load low bits
						push = 1'b1;
						// RULE_06 upper bits from latch
						s_nxt.pc = {s_r.latch[6:3], s_r.k};
						// RULE_10 two cycles, flags kept
						s_nxt.state = ST_SECOND;
					end
					OP_WDCLR: begin
						// RULE_07 counter and prescaler cleared
						s_nxt.wdog = 8'h00;
						s_nxt.pre = 8'h00;
						// RULE_08 status bits set
						s_nxt.to_n = 1'b1;
						s_nxt.slp_n = 1'b1;
					end
					OP_CALLA: begin
						// RULE_09 push return, pc from w and latch
						push     = 1'b1;
						s_nxt.pc = {s_r.latch, s_r.w};
						// RULE_10 two cycles, flags kept
						s_nxt.state = ST_SECOND;
					end
					OP_COMP, OP_DEC: begin
						// RULE_11 complement to chosen destination
						// RULE_13 decrement to chosen destination
						res = (s_r.op == OP_COMP) ? ~mem_q : (mem_q - 8'h01);
						if (s_r.d) begin
							mem_we = 1'b1;
							mem_wd = res;
						end else begin
							s_nxt.w = res;
						end
						// RULE_14 zero flag from result only
						s_nxt.z = (res == 8'h00);
					end
					OP_CLRREG: begin
						// RULE_12 clear and set zero
						mem_we  = 1'b1;
						mem_wd  = 8'h00;
						s_nxt.z = 1'b1;
					end
					default: begin
						s_nxt.state = ST_IDLE;
					end
				endcase
			end
			ST_SECOND: begin
				// RULE_15 single-cycle ops never reach here
				s_nxt.state = ST_IDLE;
			end
			default: begin
				s_nxt.state = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // cis_exec

// ===== testbench/cis_exec_chk.sv
// Purpose: port-level checks of the instruction subset executor
// Assumes: one clock domain, reset_n active low
// Notes:   shadows only follow what the bus itself wrote

`timescale 1ns/1ns

module cis_exec_chk
	import cis_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic        wr_go;
	logic        rd_go;
	logic        ins_go;
	logic        trk_go;
	logic [3:0]  op;
	logic        z_set_r;
	logic        wd_set_r;
	logic        pc_set_r;
	logic [7:0]  wd_cnt_r;
	logic [6:0]  latch_r;
	logic [14:0] pc_exp_r;

	assign wr_go  = avs_write && !avs_waitrequest;
	assign rd_go  = avs_read && !avs_waitrequest;
	assign ins_go = wr_go && avs_address == REG_INSN;
	assign op     = avs_writedata[31:28];
	// only these writes can disturb the tracked flags and pc
	assign trk_go = wr_go && avs_address inside {REG_INSN, REG_STATUS, REG_PC};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			z_set_r  <= 1'b0;
			wd_set_r <= 1'b0;
			pc_set_r <= 1'b0;
			wd_cnt_r <= 8'h00;
			latch_r  <= 7'h00;
			pc_exp_r <= 15'h0000;
		end else begin
			if (trk_go) begin
				z_set_r  <= ins_go && op == OP_CLRREG;
				wd_set_r <= ins_go && op == OP_WDCLR;
				pc_set_r <= ins_go && op == OP_CALLK;
				pc_exp_r <= {latch_r[6:3], avs_writedata[26:16]};
				wd_cnt_r <= 8'h00;
			end else if (wd_cnt_r < 8'd200) begin
				wd_cnt_r <= wd_cnt_r + 8'd1;
			end
			if (wr_go && avs_address == REG_LATCH && avs_byteenable[0])
				latch_r <= avs_writedata[6:0];
		end
	end

	AST_BRANCH_TWO: assert property ((ins_go && op == OP_BRANCH) ##1 avs_write |->
		avs_waitrequest [*3] ##1 !avs_waitrequest) else $error("branch busy time wrong");
	AST_CALL_TWO: assert property ((ins_go && op inside {OP_CALLK, OP_CALLA}) ##1 avs_write |->
		avs_waitrequest [*3] ##1 !avs_waitrequest) else $error("call busy time wrong");
	AST_ONE_CYC: assert property ((ins_go && op inside {OP_BSET, OP_WDCLR, OP_COMP, OP_CLRREG, OP_DEC})
		##1 avs_write |-> avs_waitrequest [*2] ##1 !avs_waitrequest) else $error("single cycle op too long");
	AST_BTS_TIME: assert property ((ins_go && op == OP_BTSKIP) ##1 avs_write |->
		avs_waitrequest [*2] ##[1:2] !avs_waitrequest) else $error("bit test busy time wrong");
	AST_CLR_Z: assert property (rd_go && avs_address == REG_STATUS && z_set_r |->
		avs_readdata[ST_Z_BIT]) else $error("zero flag not set by clear");
	AST_WD_BITS: assert property (rd_go && avs_address == REG_STATUS && wd_set_r |->
		avs_readdata[ST_TO_BIT] && avs_readdata[ST_SLP_BIT]) else $error("status bits not set");
	AST_WD_ZERO: assert property (rd_go && avs_address == REG_WDOG && wd_set_r && wd_cnt_r < 8'd200 |->
		avs_readdata[7:0] == 8'h00 && avs_readdata[15:8] < wd_cnt_r) else $error("watchdog not cleared");
	AST_CALLK_PC: assert property (rd_go && avs_address == REG_PC && pc_set_r |->
		avs_readdata[14:0] == pc_exp_r) else $error("call target wrong");

	COV_CALL: cover property (ins_go && op == OP_CALLK);
	COV_WDCLR: cover property (rd_go && avs_address == REG_WDOG && wd_set_r);
	COV_STALL: cover property (avs_write && avs_waitrequest);
endmodule // cis_exec_chk

bind cis_exec cis_exec_chk i_cis_exec_chk (
	.clk            (clk),
	.reset_n        (reset_n),
	.avs_address    (avs_address),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_writedata  (avs_writedata),
	.avs_byteenable (avs_byteenable),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);

// ===== testbench/cis_exec_tb_top.sv
// Purpose: self-checking bench of the instruction subset executor
// Assumes: waitrequest and read data are sampled at the rising edge
// Notes:   writes keep the strobe up back to back so busy stalls are hit

`timescale 1ns/1ns

module cis_exec_tb_top
	import cis_pkg::*;
;
	logic        clk;
	logic        reset_n;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          bad_count;
	int          checked;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [14:0] pc_v;
	logic [7:0]  w_v;
	logic [7:0]  v;
	logic [7:0]  res;
	logic [6:0]  lat_v;
	logic [6:0]  f_v;
	logic [10:0] k_v;
	logic [3:0]  sp_v;
	logic [3:0]  op_v;

	cis_exec i_cis_exec (
		.clk            (clk),
		.reset_n        (reset_n),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (avs_byteenable),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----
	// bus tasks
	// ----
	// all bench inputs move by nba, so the edge sees the settled waitrequest
	task automatic wait_ack();
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		avs_read       <= 1'b0;
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= 1'b1;
		wait_ack();
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		exp_q.push_back(e);
		msk_q.push_back(m);
		avs_write   <= 1'b0;
		avs_address <= a;
		avs_read    <= 1'b1;
		wait_ack();
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	// the trailing write to an unmapped place lands on the busy window
	task automatic go(input logic [3:0] op, input logic [6:0] f, input logic [2:0] b, input logic d,
		input logic [10:0] k);
		wr(REG_INSN, {op, 1'b0, k, 5'h00, d, b, f});
		wr(6'h3c, $urandom());
	endtask

	task automatic cmp_rd(input logic [31:0] got);
		logic [31:0] e;
		logic [31:0] m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		checked++;
		if ((got & m) !== (e & m)) begin
			bad_count++;
			$display("ERROR %0t read %h expected %h mask %h", $time, got, e, m);
		end
	endtask

	task automatic wrap_up();
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk) begin
		if (reset_n === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0)
			cmp_rd(avs_readdata);
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	// ----
	// scenarios
	// ----
	initial begin
		reset_n        = 1'b0;
		avs_address    = 6'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
		bad_count      = 0;
		checked        = 0;
		sp_v           = 4'h0;
		void'($urandom(32'h052e7889));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(REG_STATUS, 32'h6);
		rd(6'h3c, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pc_v = (i == 0) ? 15'h7f80 : 15'($urandom());
			w_v = (i == 0) ? 8'hff : 8'($urandom());
			wr(REG_PC, {17'h0, pc_v});
			wr(REG_W, {24'h0, w_v});
			go(OP_BRANCH, 7'h00, 3'h0, 1'b0, 11'h000);
			rd(REG_PC, {17'h0, pc_v + 15'd1 + {7'h00, w_v}});
		end
		// a disabled byte lane keeps its old contents
		wr(REG_PC, 32'h1234);
		wr(REG_PC, 32'hffff_ffab, 4'h1);
		rd(REG_PC, 32'h12ab);
		f_v = 7'h7f;
		wr(REG_MEM_ADDR, {25'h0, f_v});
		wr(REG_MEM_DATA, 32'h0);
		wr(REG_STATUS, 32'h7);
		for (int b = 0; b < 8; b++) begin
			go(OP_BSET, f_v, 3'(b), 1'b0, 11'h000);
			rd(REG_MEM_DATA, (32'h2 << b) - 32'h1);
		end
		rd(REG_STATUS, 32'h7, 32'h7);
		v = 8'($urandom());
		wr(REG_MEM_DATA, {24'h0, v});
		for (int b = 0; b < 8; b++) begin
			pc_v = 15'($urandom());
			wr(REG_PC, {17'h0, pc_v});
			go(OP_BTSKIP, f_v, 3'(b), 1'b0, 11'h000);
			rd(REG_PC, {17'h0, pc_v + 15'd1 + 15'(v[b])});
		end
		for (int i = 0; i < 4; i++) begin
			op_v = i[0] ? OP_CALLA : OP_CALLK;
			pc_v = (i < 2) ? 15'h7fff : 15'($urandom());
			k_v = (i == 0) ? 11'h7ff : 11'($urandom());
			lat_v = 7'($urandom());
			w_v = 8'($urandom());
			wr(REG_LATCH, {25'h0, lat_v});
			wr(REG_W, {24'h0, w_v});
			wr(REG_PC, {17'h0, pc_v});
			wr(REG_STATUS, 32'h5);
			go(op_v, 7'h00, 3'h0, 1'b0, k_v);
			sp_v++;
			rd(REG_PC, {17'h0, i[0] ? {lat_v, w_v} : {lat_v[6:3], k_v}});
			rd(REG_STACK, {12'h0, sp_v, 1'b0, pc_v + 15'd1});
			rd(REG_STATUS, 32'h5, 32'h7);
		end
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS, 32'h1, 32'h7);
		repeat (600) @(posedge clk);
		go(OP_WDCLR, 7'h00, 3'h0, 1'b0, 11'h000);
		rd(REG_WDOG, 32'h0, 32'h0000f0ff);
		rd(REG_STATUS, 32'h7, 32'h7);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($urandom());
			op_v = i[0] ? OP_COMP : OP_DEC;
			res = i[0] ? ~v : v - 8'd1;
			f_v = 7'($urandom());
			wr(REG_W, 32'h5a);
			wr(REG_MEM_ADDR, {25'h0, f_v});
			wr(REG_MEM_DATA, {24'h0, v});
			wr(REG_STATUS, {29'h0, 2'b11, res != 8'h00});
			go(op_v, f_v, 3'h0, i[1], 11'h000);
			rd(REG_W, {24'h0, i[1] ? 8'h5a : res});
			rd(REG_MEM_DATA, {24'h0, i[1] ? res : v});
			rd(REG_STATUS, {29'h0, 2'b11, res == 8'h00}, 32'h7);
		end
		wr(REG_MEM_DATA, 32'ha5);
		wr(REG_STATUS, 32'h6);
		go(OP_CLRREG, f_v, 3'h0, 1'b0, 11'h000);
		rd(REG_MEM_DATA, 32'h0);
		rd(REG_STATUS, 32'h7, 32'h7);
		rd(6'h3c, 32'h0);
		wrap_up();
	end
endmodule // cis_exec_tb_top
